// File: inc/setpoint_if.sv
// Carrier between the trip logic and its setpoint store.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
interface setpoint_if;
    logic wr_req;
    trip_pkg::sp_idx_t wr_idx;
    trip_pkg::reading_t wr_val;
    logic key_ok;
    logic accepted;
    logic refused;
    logic [trip_pkg::NSP-1:0][trip_pkg::RW-1:0] sp;
    modport store (input wr_req, wr_idx, wr_val, key_ok, output accepted, refused, sp);
    modport user (output wr_req, wr_idx, wr_val, key_ok, input accepted, refused, sp);
endinterface

// File: inc/trip_pkg.sv
// Shared constants for the trip and annunciator logic: reading slots,
// setpoint slots and limits, annunciator cause bits and timing counts.
// Assumes a single 125 MHz system clock; readings are 0.1-unit integers.
package trip_pkg;

    // ------------------------------------------------------------------
    // Widths and counts
    // ------------------------------------------------------------------
    localparam int RW = 16;
    localparam int NRD = 12;
    localparam int NSP = 12;
    localparam int SP_SLOTS = 16;
    localparam int ANN_N = 16;
    localparam int NROD = 2;
    localparam int NPIN = 8;
    localparam int ACK_W = 28;

    typedef logic [RW-1:0] reading_t;
    typedef logic [3:0] sp_idx_t;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_KHZ = 125000;
    localparam int ACK_HOLD_MS = 2000;
    localparam int ACK_HOLD_CYCLES_DEF = ACK_HOLD_MS * CLK_KHZ;

    // ------------------------------------------------------------------
    // Reading slots (count rate in 0.1 cps, rates in 0.1 %/s, power in
    // 0.1 kW, percentages in 0.1 %, dose rates in 0.1 mR/hr)
    // ------------------------------------------------------------------
    localparam int RD_CR_COUNT = 0;
    localparam int RD_CR_RATE = 1;
    localparam int RD_LOG_RATE = 2;
    localparam int RD_LOG_KW = 3;
    localparam int RD_LOG_PCT = 4;
    localparam int RD_SAFE_KW = 5;
    localparam int RD_SAFE_PCT = 6;
    localparam int RD_LIN_PCT = 7;
    localparam int RD_POOL_RAD = 8;
    localparam int RD_POOL_BG2X = 9;
    localparam int RD_WATER_RAD = 10;
    localparam int RD_CONSOLE_RAD = 11;
    localparam reading_t RD_HIGH = 16'hFFFF;
    localparam reading_t RD_LIN_HIGH = 16'h7FFF;
    localparam reading_t RD_LOW = 16'h0000;

    // ------------------------------------------------------------------
    // Setpoint slots, their ceilings (also the reset values) and order
    // ------------------------------------------------------------------
    localparam int SP_CR_MIN = 0;
    localparam int SP_RATE_INH = 1;
    localparam int SP_RATE_SB = 2;
    localparam int SP_RATE_SCR = 3;
    localparam int SP_KW_SB = 4;
    localparam int SP_KW_SCR = 5;
    localparam int SP_PCT_SB = 6;
    localparam int SP_PCT_SCR = 7;
    localparam int SP_LIN_SB = 8;
    localparam int SP_LIN_SCR = 9;
    localparam int SP_RAD_POOL = 10;
    localparam int SP_RAD_SMALL = 11;
    localparam sp_idx_t SP_NONE = 4'hF;
    localparam reading_t SP_LIMIT [SP_SLOTS] = '{
        16'h0014, 16'h0042, 16'h0050, 16'h008C, 16'h006E, 16'h0078,
        16'h044C, 16'h04B0, 16'h044C, 16'h04B0, 16'h01F4, 16'h004B,
        16'h0000, 16'h0000, 16'h0000, 16'h0000};
    localparam sp_idx_t SP_LOWER [SP_SLOTS] = '{
        4'hF, 4'hF, 4'h1, 4'h2, 4'hF, 4'h4, 4'hF, 4'h6,
        4'hF, 4'h8, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF};
    localparam sp_idx_t SP_UPPER [SP_SLOTS] = '{
        4'hF, 4'h2, 4'h3, 4'hF, 4'h5, 4'hF, 4'h7, 4'hF,
        4'h9, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF, 4'hF};

    // ------------------------------------------------------------------
    // Pin slots and annunciator cause bits
    // ------------------------------------------------------------------
    localparam int P_SCR_CON = 0;
    localparam int P_SCR_HALL = 1;
    localparam int P_KEY_RUN = 2;
    localparam int P_KEY_SP = 3;
    localparam int P_ACK = 4;
    localparam int P_EVAC = 5;
    localparam int P_ROD = 6;
    localparam int A_CR_LOW = 0;
    localparam int A_RATE_INH = 1;
    localparam int A_CR_RATE_SB = 2;
    localparam int A_CR_RATE_SCR = 3;
    localparam int A_LOG_RATE_SB = 4;
    localparam int A_LOG_RATE_SCR = 5;
    localparam int A_LOG_PWR_SCR = 6;
    localparam int A_SAFE_SB = 7;
    localparam int A_SAFE_SCR = 8;
    localparam int A_LIN_SB = 9;
    localparam int A_LIN_ZERO = 10;
    localparam int A_LIN_SCR = 11;
    localparam int A_RAD_SCR = 12;
    localparam int A_MANUAL = 13;
    localparam int A_BAD = 14;
    localparam int A_KEY_OFF = 15;
    localparam logic [ANN_N-1:0] SCRAM_MASK = 16'hF968;
    localparam logic [ANN_N-1:0] SB_MASK = 16'h0694;
    localparam logic [ANN_N-1:0] INH_MASK = 16'h0003;

endpackage

// File: rtl/pin_sync.sv
// Three-stage synchroniser for console pins, with agreement filter.
// Assumes inputs are asynchronous; output resets to zero (tripped sense).
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
        end
    end

    // A change is taken only once the second and third stages agree.
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                q[i] <= 1'b0;
            end else if (s2[i] == s3[i]) begin
                q[i] <= s3[i];
            end
        end
    end
endmodule // pin_sync

// File: rtl/setpoint_store.sv
// Setpoint memory with key-gated, ceiling-checked writes.
// Assumes write requests come from logic on the system clock.
`timescale 1ns/10ps
module setpoint_store (
    input wire logic sys_clk,
    input wire logic reset,
    setpoint_if.store spi
);
    import trip_pkg::*;

    logic ok;
    sp_idx_t lo;
    sp_idx_t hi;

    always_comb begin
        lo = SP_LOWER[spi.wr_idx];
        hi = SP_UPPER[spi.wr_idx];
        ok = spi.key_ok && (int'(spi.wr_idx) < NSP) && (spi.wr_val <= SP_LIMIT[spi.wr_idx]);
        // A setback must stay below its scram, so ordering is kept on every write.
        if (lo != SP_NONE && spi.wr_val <= spi.sp[lo]) begin
            ok = 1'b0;
        end
        if (hi != SP_NONE && spi.wr_val >= spi.sp[hi]) begin
            ok = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int i = 0; i < NSP; i++) begin
                spi.sp[i] <= SP_LIMIT[i];
            end
            spi.accepted <= 1'b0;
            spi.refused <= 1'b0;
        end else begin
            spi.accepted <= spi.wr_req && ok;
            spi.refused <= spi.wr_req && !ok;
            if (spi.wr_req && ok) begin
                spi.sp[spi.wr_idx] <= spi.wr_val;
            end
        end
    end

    key_gate_a: assert property (@(posedge sys_clk) disable iff (reset)
        spi.wr_req && !spi.key_ok |=> spi.refused && $stable(spi.sp))
        else $error("setpoint changed without key");
    ceiling_a: assert property (@(posedge sys_clk) disable iff (reset)
        spi.wr_req && spi.wr_val > SP_LIMIT[spi.wr_idx] |=> spi.refused && !spi.accepted)
        else $error("setpoint above ceiling accepted");
endmodule // setpoint_store

// File: rtl/trip_annunciator_logic.sv
// Protective trip, setback, inhibit and annunciator logic.
// Assumes channel readings and quality flags arrive on sys_clk; console
// pins are asynchronous; scram and key pins are closed-circuit (high means healthy).
`timescale 1ns/10ps

module trip_annunciator_logic #(
    parameter int unsigned ACK_HOLD_CYCLES = trip_pkg::ACK_HOLD_CYCLES_DEF
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [trip_pkg::NRD-1:0][trip_pkg::RW-1:0] readings,
    input wire logic [trip_pkg::NRD-1:0] reading_good,
    input wire logic scram_console_ok,
    input wire logic scram_hallway_ok,
    input wire logic key_run,
    input wire logic key_setpoint,
    input wire logic ack_button,
    input wire logic evac_button,
    input wire logic [trip_pkg::NROD-1:0] rod_at_lower,
    input wire logic ann_test,
    input wire logic sp_wr_req,
    input wire trip_pkg::sp_idx_t sp_wr_idx,
    input wire trip_pkg::reading_t sp_wr_val,
    output logic sp_accepted,
    output logic sp_refused,
    output logic magnet_enable,
    output logic scram_latched,
    output logic setback_n,
    output logic inhibit_n,
    output logic alarm_sound,
    output logic [trip_pkg::ANN_N-1:0] panel_lamp,
    output logic [trip_pkg::ANN_N-1:0] ws_lamp,
    output logic evac_horn
);
    import trip_pkg::*;

    localparam logic [ACK_W-1:0] ACK_LAST = ACK_W'(ACK_HOLD_CYCLES - 1);

    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s;
    logic [NRD-1:0][RW-1:0] rd;
    logic [NSP-1:0][RW-1:0] sp;
    logic [ANN_N-1:0] cause;
    logic [ANN_N-1:0] cause_q;
    logic [ANN_N-1:0] cause_rise;
    logic [ANN_N-1:0] unack;
    logic [ACK_W-1:0] ack_cnt;
    logic ack_q;
    logic ack_rise;
    logic ack_held;
    logic rods_down;
    logic rearm;
    logic scram_now;
    logic lin_prev_pos;
    logic lin_zero;
    logic lin_cross;
    reading_t pool_sp;

    // ------------------------------------------------------------------
    // Console pins and setpoint store
    // ------------------------------------------------------------------
    assign pin_raw = {rod_at_lower, evac_button, ack_button, key_setpoint,
                      key_run, scram_hallway_ok, scram_console_ok};

    pin_sync #(.W(NPIN)) u_pin_sync (
        .sys_clk(sys_clk),
        .reset(reset),
        .d(pin_raw),
        .q(pin_s)
    );

    setpoint_if spi ();
    assign spi.wr_req = sp_wr_req;
    assign spi.wr_idx = sp_wr_idx;
    assign spi.wr_val = sp_wr_val;
    assign spi.key_ok = pin_s[P_KEY_SP];
    assign sp = spi.sp;
    assign sp_accepted = spi.accepted;
    assign sp_refused = spi.refused;

    setpoint_store u_setpoint_store (
        .sys_clk(sys_clk),
        .reset(reset),
        .spi(spi)
    );

    // ------------------------------------------------------------------
    // Conservative substitution of bad readings
    // ------------------------------------------------------------------
    // Count rate trips low, linear is signed, everything else trips high.
    for (genvar i = 0; i < NRD; i++) begin : g_rd
        if (i == RD_CR_COUNT) begin : g_low
            assign rd[i] = reading_good[i] ? readings[i] : RD_LOW;
        end else if (i == RD_LIN_PCT) begin : g_lin
            assign rd[i] = reading_good[i] ? readings[i] : RD_LIN_HIGH;
        end else begin : g_high
            assign rd[i] = reading_good[i] ? readings[i] : RD_HIGH;
        end
    end

    // ------------------------------------------------------------------
    // Zero-of-range crossing on the linear channel
    // ------------------------------------------------------------------
    assign lin_cross = reading_good[RD_LIN_PCT] && lin_prev_pos && $signed(rd[RD_LIN_PCT]) < 0;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            lin_prev_pos <= 1'b0;
            lin_zero <= 1'b0;
        end else begin
            lin_prev_pos <= $signed(rd[RD_LIN_PCT]) > 0;
            // The setback holds until the reading is back at or above zero.
            if (lin_cross) begin
                lin_zero <= 1'b1;
            end else if ($signed(rd[RD_LIN_PCT]) >= 0) begin
                lin_zero <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Setpoint comparisons
    // ------------------------------------------------------------------
    assign pool_sp = (sp[SP_RAD_POOL] < rd[RD_POOL_BG2X]) ? sp[SP_RAD_POOL] : rd[RD_POOL_BG2X];

    always_comb begin
        cause = '0;
        cause[A_CR_LOW] = rd[RD_CR_COUNT] <= sp[SP_CR_MIN];
        cause[A_RATE_INH] = rd[RD_CR_RATE] >= sp[SP_RATE_INH]
                         || rd[RD_LOG_RATE] >= sp[SP_RATE_INH];
        cause[A_CR_RATE_SB] = rd[RD_CR_RATE] >= sp[SP_RATE_SB];
        cause[A_CR_RATE_SCR] = rd[RD_CR_RATE] >= sp[SP_RATE_SCR];
        cause[A_LOG_RATE_SB] = rd[RD_LOG_RATE] >= sp[SP_RATE_SB];
        cause[A_LOG_RATE_SCR] = rd[RD_LOG_RATE] >= sp[SP_RATE_SCR];
        cause[A_LOG_PWR_SCR] = rd[RD_LOG_KW] >= sp[SP_KW_SCR]
                            || rd[RD_LOG_PCT] >= sp[SP_PCT_SCR];
        cause[A_SAFE_SB] = rd[RD_SAFE_KW] >= sp[SP_KW_SB]
                        || rd[RD_SAFE_PCT] >= sp[SP_PCT_SB];
        cause[A_SAFE_SCR] = rd[RD_SAFE_KW] >= sp[SP_KW_SCR]
                         || rd[RD_SAFE_PCT] >= sp[SP_PCT_SCR];
        cause[A_LIN_SB] = $signed(rd[RD_LIN_PCT]) >= $signed(sp[SP_LIN_SB]);
        cause[A_LIN_ZERO] = lin_zero;
        cause[A_LIN_SCR] = $signed(rd[RD_LIN_PCT]) >= $signed(sp[SP_LIN_SCR]);
        cause[A_RAD_SCR] = rd[RD_POOL_RAD] >= pool_sp
                        || rd[RD_WATER_RAD] >= sp[SP_RAD_SMALL]
                        || rd[RD_CONSOLE_RAD] >= sp[SP_RAD_SMALL];
        cause[A_MANUAL] = !pin_s[P_SCR_CON] || !pin_s[P_SCR_HALL];
        cause[A_BAD] = !(&reading_good);
        cause[A_KEY_OFF] = !pin_s[P_KEY_RUN];
    end

    // ------------------------------------------------------------------
    // Magnet power chain and re-enable sequence
    // ------------------------------------------------------------------
    // Only the SCRAM_MASK causes feed the series chain; there is no mask or bypass input.
    assign scram_now = |(cause & SCRAM_MASK);
    assign ack_held = pin_s[P_ACK];
    assign rods_down = &pin_s[P_ROD +: NROD];
    assign rearm = ack_held && ack_cnt == ACK_LAST && rods_down && !scram_now;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ack_cnt <= '0;
        end else if (!ack_held) begin
            ack_cnt <= '0;
        end else if (ack_cnt != ACK_LAST) begin
            ack_cnt <= ack_cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            scram_latched <= 1'b1;
        end else if (scram_now) begin
            scram_latched <= 1'b1;
        end else if (rearm) begin
            scram_latched <= 1'b0;
        end
    end

    // Outputs sit low under reset so a dead block reads as tripped.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            magnet_enable <= 1'b0;
            setback_n <= 1'b0;
            inhibit_n <= 1'b0;
        end else begin
            magnet_enable <= !scram_latched && !scram_now;
            setback_n <= !(|(cause & SB_MASK));
            inhibit_n <= !(|(cause & (INH_MASK | SB_MASK | SCRAM_MASK)));
        end
    end

    // ------------------------------------------------------------------
    // Annunciator
    // ------------------------------------------------------------------
    assign cause_rise = cause & ~cause_q;
    assign ack_rise = ack_held && !ack_q;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cause_q <= '0;
            ack_q <= 1'b0;
        end else begin
            cause_q <= cause;
            ack_q <= ack_held;
        end
    end

    // A new rise wins over an acknowledge in the same cycle.
    for (genvar i = 0; i < ANN_N; i++) begin : g_ann
        always_ff @(posedge sys_clk) begin
            if (reset) begin
                unack[i] <= 1'b0;
            end else if (cause_rise[i]) begin
                unack[i] <= 1'b1;
            end else if (ack_rise) begin
                unack[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            panel_lamp <= '0;
            alarm_sound <= 1'b0;
            evac_horn <= 1'b0;
        end else begin
            panel_lamp <= ann_test ? '1 : (cause | unack);
            alarm_sound <= ann_test || (|cause_rise) || (|unack && !ack_rise);
            evac_horn <= pin_s[P_EVAC];
        end
    end

    assign ws_lamp = panel_lamp;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    scram_open_a: assert property (@(posedge sys_clk) disable iff (reset)
        scram_now |=> !magnet_enable)
        else $error("magnet power on during scram");
    rearm_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(magnet_enable) |-> $past(rearm, 2))
        else $error("magnet re-enabled without full acknowledge hold");
    rods_down_a: assert property (@(posedge sys_clk) disable iff (reset)
        $rose(magnet_enable) |-> $past(rods_down, 2))
        else $error("magnet re-enabled with a rod off its lower limit");
    latch_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
        scram_latched && !rearm |=> scram_latched ##1 !magnet_enable)
        else $error("scram latch released early");
    lamp_hold_a: assert property (@(posedge sys_clk) disable iff (reset)
        cause != '0 |=> ((panel_lamp & $past(cause)) == $past(cause)))
        else $error("lamp dark while cause active");
    silence_a: assert property (@(posedge sys_clk) disable iff (reset)
        ack_rise && !ann_test && cause_rise == '0 |=> !alarm_sound)
        else $error("alarm not silenced by acknowledge");
    new_alarm_a: assert property (@(posedge sys_clk) disable iff (reset)
        cause_rise != '0 |=> alarm_sound)
        else $error("new cause did not sound alarm");
    lamp_test_a: assert property (@(posedge sys_clk) disable iff (reset)
        ann_test |=> alarm_sound && (&panel_lamp) && (&ws_lamp))
        else $error("test did not exercise panel");
    evac_horn_a: assert property (@(posedge sys_clk) disable iff (reset)
        pin_s[P_EVAC] |=> evac_horn)
        else $error("evacuation horn not driven");
    low_count_a: assert property (@(posedge sys_clk) disable iff (reset)
        rd[RD_CR_COUNT] <= sp[SP_CR_MIN] |=> !inhibit_n)
        else $error("withdrawal permitted at low count rate");
    setback_out_a: assert property (@(posedge sys_clk) disable iff (reset)
        rd[RD_SAFE_KW] >= sp[SP_KW_SB] |=> !setback_n)
        else $error("setback not asserted");
    bad_read_a: assert property (@(posedge sys_clk) disable iff (reset)
        !(&reading_good) |=> !magnet_enable ##1 scram_latched)
        else $error("bad reading did not scram");
    zero_cross_a: assert property (@(posedge sys_clk) disable iff (reset)
        lin_cross |=> lin_zero ##1 !setback_n)
        else $error("zero crossing missed");
endmodule // trip_annunciator_logic

// File: tb/far_side.sv
// Model of the channels, radiation monitors and console pins.
// Assumes the bench calls its tasks just after a rising clock edge.
`timescale 1ns/10ps
module far_side (
    output logic [trip_pkg::NRD-1:0][trip_pkg::RW-1:0] readings,
    output logic [trip_pkg::NRD-1:0] reading_good,
    output logic [7:0] pins
);
    import trip_pkg::*;
    // Healthy plant: circuits closed, keys on, rods down, readings safe.
    initial begin
        readings = '0;
        readings[RD_CR_COUNT] = 16'h0100;
        readings[RD_POOL_BG2X] = 16'h0FFF;
        reading_good = '1;
        pins = 8'hCF;
    end
    task automatic set_rd(input int i, input reading_t v);
        readings[i] = v;
    endtask
    task automatic set_good(input int i, input logic v);
        reading_good[i] = v;
    endtask
    task automatic set_pin(input int i, input logic v);
        pins[i] = v;
    endtask
endmodule // far_side

// File: tb/tb_top.sv
// Self-checking bench for the trip and annunciator logic.
// Assumes the design package and the far-side model are compiled first.
`timescale 1ns/10ps
module tb_top;
    import trip_pkg::*;
    logic sys_clk, reset, ann_test, sp_wr_req, sp_accepted, sp_refused;
    logic magnet_enable, scram_latched, setback_n, inhibit_n, alarm_sound, evac_horn;
    logic [NRD-1:0][RW-1:0] rd;
    logic [NRD-1:0] good;
    logic [7:0] pin;
    logic [ANN_N-1:0] panel_lamp, ws_lamp;
    sp_idx_t sp_wr_idx;
    reading_t sp_wr_val;
    int fails = 0;
    int tests_run = 0;
    far_side far (.readings(rd), .reading_good(good), .pins(pin));
    trip_annunciator_logic #(.ACK_HOLD_CYCLES(20)) dut (.sys_clk(sys_clk), .reset(reset),
        .readings(rd), .reading_good(good), .scram_console_ok(pin[P_SCR_CON]),
        .scram_hallway_ok(pin[P_SCR_HALL]), .key_run(pin[P_KEY_RUN]),
        .key_setpoint(pin[P_KEY_SP]), .ack_button(pin[P_ACK]), .evac_button(pin[P_EVAC]),
        .rod_at_lower(pin[7:6]), .ann_test(ann_test), .sp_wr_req(sp_wr_req),
        .sp_wr_idx(sp_wr_idx), .sp_wr_val(sp_wr_val), .sp_accepted(sp_accepted),
        .sp_refused(sp_refused), .magnet_enable(magnet_enable),
        .scram_latched(scram_latched), .setback_n(setback_n), .inhibit_n(inhibit_n),
        .alarm_sound(alarm_sound), .panel_lamp(panel_lamp), .ws_lamp(ws_lamp),
        .evac_horn(evac_horn));
    initial begin
        sys_clk = 0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Holding acknowledge well past the shortened count re-arms only if all is clear.
    task automatic rearm(input logic m);
        far.set_pin(P_ACK, 1);
        cyc(30);
        far.set_pin(P_ACK, 0);
        cyc(6);
        chk("magnet_enable", 16'(m), 16'(magnet_enable));
        chk("scram_latched", 16'(!m), 16'(scram_latched));
        chk("alarm_sound", 16'h0000, 16'(alarm_sound));
    endtask
    task automatic rd_chk(input int i, input reading_t v, input string n, input logic e,
        input logic g_sel);
        far.set_rd(i, v);
        cyc(2);
        chk(n, 16'(e), g_sel ? 16'(setback_n) : 16'(inhibit_n));
    endtask
    task automatic t_trips;
        rd_chk(RD_CR_COUNT, 16'h0015, "inhibit_n", 1, 0);
        rd_chk(RD_CR_COUNT, 16'h0014, "inhibit_n", 0, 0);
        rd_chk(RD_CR_COUNT, 16'h0100, "inhibit_n", 1, 0);
        rd_chk(RD_SAFE_KW, 16'h006D, "setback_n", 1, 1);
        rd_chk(RD_SAFE_KW, 16'h006E, "setback_n", 0, 1);
        chk("lamps", 16'h0180, 16'({panel_lamp[7], ws_lamp[7]}) << 7);
        chk("magnet_enable", 16'h0001, 16'(magnet_enable));
        rd_chk(RD_SAFE_KW, 16'h0078, "setback_n", 0, 1);
        chk("magnet_enable", 16'h0000, 16'(magnet_enable));
        rd_chk(RD_SAFE_KW, 16'h0000, "setback_n", 1, 1);
        chk("scram_latched", 16'h0001, 16'(scram_latched));
        chk("lamp_8", 16'h0001, 16'(panel_lamp[8]));
    endtask
    task automatic wr(input sp_idx_t i, input reading_t v, input logic [1:0] e);
        logic [1:0] s;
        sp_wr_req = 1;
        sp_wr_idx = i;
        sp_wr_val = v;
        cyc(1);
        sp_wr_req = 0;
        s = {sp_accepted, sp_refused};
        cyc(1);
        s = s | {sp_accepted, sp_refused};
        chk("sp_answer", 16'(e), 16'(s));
    endtask
    task automatic t_setpoint;
        wr(4'(SP_KW_SCR), 16'h0079, 2'b01);
        wr(4'(SP_KW_SB), 16'h0064, 2'b10);
        wr(4'(SP_KW_SCR), 16'h0064, 2'b01);
        rd_chk(RD_SAFE_KW, 16'h0064, "setback_n", 0, 1);
        far.set_rd(RD_SAFE_KW, 16'h0000);
        far.set_pin(P_KEY_SP, 0);
        cyc(6);
        wr(4'(SP_KW_SB), 16'h0050, 2'b01);
        far.set_pin(P_KEY_SP, 1);
    endtask
    task automatic t_panel;
        ann_test = 1;
        cyc(2);
        chk("panel_lamp", 16'hFFFF, panel_lamp);
        chk("ws_lamp", 16'hFFFF, ws_lamp);
        chk("alarm_sound", 16'h0001, 16'(alarm_sound));
        ann_test = 0;
        far.set_pin(P_EVAC, 1);
        cyc(6);
        chk("evac_horn", 16'h0001, 16'(evac_horn));
        far.set_pin(P_EVAC, 0);
    endtask
    // Channels the threshold walk leaves alone; the pool and water scrams share one re-arm, linear and bad-reading get their own, hallway none.
    task automatic t_channels;
        rd_chk(RD_CR_RATE, 16'h0042, "inhibit_n", 0, 0);
        rd_chk(RD_CR_RATE, 16'h0050, "setback_n", 0, 1);
        rd_chk(RD_CR_RATE, 16'h0000, "setback_n", 1, 1);
        rd_chk(RD_LIN_PCT, 16'hFFF0, "setback_n", 1, 1);
        rd_chk(RD_LIN_PCT, 16'h0010, "setback_n", 1, 1);
        rd_chk(RD_LIN_PCT, 16'hFFF0, "setback_n", 0, 1);
        rd_chk(RD_LIN_PCT, 16'h0000, "setback_n", 1, 1);
        rd_chk(RD_LIN_PCT, 16'h04B0, "setback_n", 0, 1);
        chk("magnet_enable", 16'h0000, 16'(magnet_enable));
        far.set_rd(RD_LIN_PCT, 16'h0000);
        rearm(1);
        far.set_rd(RD_POOL_BG2X, 16'h0064);
        rd_chk(RD_POOL_RAD, 16'h0063, "inhibit_n", 1, 0);
        rd_chk(RD_POOL_RAD, 16'h0064, "inhibit_n", 0, 0);
        chk("magnet_enable", 16'h0000, 16'(magnet_enable));
        far.set_rd(RD_POOL_RAD, 16'h0000);
        far.set_rd(RD_POOL_BG2X, 16'h0FFF);
        rd_chk(RD_WATER_RAD, 16'h004A, "inhibit_n", 1, 0);
        rd_chk(RD_WATER_RAD, 16'h004B, "inhibit_n", 0, 0);
        far.set_rd(RD_WATER_RAD, 16'h0000);
        rearm(1);
        far.set_good(RD_CR_COUNT, 0);
        cyc(2);
        chk("magnet_enable", 16'h0000, 16'(magnet_enable));
        chk("bad_lamps", 16'h0003, 16'({panel_lamp[A_BAD], panel_lamp[A_CR_LOW]}));
        far.set_good(RD_CR_COUNT, 1);
        rearm(1);
        far.set_pin(P_SCR_HALL, 0);
        cyc(6);
        chk("magnet_enable", 16'h0000, 16'(magnet_enable));
        far.set_pin(P_SCR_HALL, 1);
    endtask
    initial begin
        reset = 1;
        ann_test = 0;
        sp_wr_req = 0;
        sp_wr_idx = '0;
        sp_wr_val = '0;
        cyc(6);
        chk("magnet_enable", 16'h0000, 16'(magnet_enable));
        chk("scram_latched", 16'h0001, 16'(scram_latched));
        reset = 0;
        cyc(8);
        rearm(1);
        t_trips();
        far.set_pin(6, 0);
        rearm(0);
        far.set_pin(6, 1);
        rearm(1);
        t_setpoint();
        t_panel();
        t_channels();
        tally_and_finish();
    end
    // Cuts a hang short; the whole sequence needs a few hundred cycles.
    initial begin
        #20000;
        fails++;
        tally_and_finish();
    end
endmodule // tb_top
